//--- hw/dstream_mmu.sv
// Data-stream fault capture, parity status and translation buffer invalidate block.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dstream_mmu
	import dstream_mmu_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         power_on,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [7:0]   awaddr,
	input  wire logic [2:0]   awprot,
	input  wire logic         wvalid,
	output logic              wready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	output logic              bvalid,
	input  wire logic         bready,
	output logic [1:0]        bresp,
	input  wire logic         arvalid,
	output logic              arready,
	input  wire logic [7:0]   araddr,
	input  wire logic [2:0]   arprot,
	output logic              rvalid,
	input  wire logic         rready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	input  wire fault_event_t fault_in,
	input  wire perr_type_t   perr_pipe0,
	input  wire perr_type_t   perr_pipe1,
	input  wire logic [63:0]  perr_vaddr,
	input  wire logic         fill_valid,
	input  wire fill_t        fill_in,
	input  wire logic         fetch_tb_miss,
	input  wire logic         pc_mispredict,
	input  wire logic         user_mode
);

	typedef struct packed {
		logic                    aw_got;
		logic [7:0]              aw_addr;
		logic                    w_got;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic [63:0]             hold;
		logic                    fault_lock;
		fault_stat_t             fstat;
		logic [63:0]             faddr;
		logic [63:0]             form;
		logic [63:0]             base;
		logic                    perr_lock;
		logic                    second_error_flag;
		perr_type_t              ptype;
		logic                    entry32_mode;
		logic [ASN_W-1:0]        space_number;
		logic [31:0]             inv_low;
		logic [PTR_W-1:0]        ptr;
		tb_entry_t [TB_ENTRIES-1:0] tb;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [63:0] format_addr(input logic [63:0] base_v,
		input logic [63:0] va, input logic mode32);
		if (mode32) begin
			return {base_v[63:30], 8'h00, va[31:13], 3'h0}; // R09
		end
		return {base_v[63:33], va[42:13], 3'h0}; // R08
	endfunction : format_addr

	logic        do_write;
	logic        ar_take;
	logic        unlock_read;
	logic        inv_single;
	logic        fault_any;
	logic        fault_lock_eff;
	logic        perr_any;
	logic        lock_eff;
	logic [63:0] ev_addr;
	fault_stat_t ev_stat;
	logic [31:0] wr_val;
	logic [63:0] inv_addr;
	logic [7:0]  valid_cnt;

	always_comb begin
		st_nxt      = st_r;
		do_write    = st_r.aw_got && st_r.w_got && !st_r.bvalid;
		ar_take     = arvalid && !st_r.rvalid;
		unlock_read = 1'b0;
		inv_single  = 1'b0;
		wr_val      = 32'h0000_0000;
		inv_addr    = 64'h0;
		valid_cnt   = 8'h00;
		// A live-entry count lets software see what an invalidate removed.
		for (int i = 0; i < TB_ENTRIES; i++) begin
			valid_cnt = valid_cnt + {7'h00, st_r.tb[i].valid};
		end

		// Write address and data are taken independently, in either order.
		if (awvalid && !st_r.aw_got && !st_r.bvalid) begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && !st_r.w_got && !st_r.bvalid) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.w_data = wdata;
			st_nxt.w_strb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end

		if (do_write) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = RESP_OKAY;
			case (st_r.aw_addr)
				OFF_BASE_LO: begin
					st_nxt.base[31:0] = merge(st_r.base[31:0], st_r.w_data, st_r.w_strb); // R10
				end
				OFF_BASE_HI: begin
					st_nxt.base[63:32] = merge(st_r.base[63:32], st_r.w_data, st_r.w_strb); // R10
				end
				OFF_PARITY_STAT: begin
					wr_val = merge(32'h0, st_r.w_data, st_r.w_strb);
					if (wr_val[POS_LOCK]) begin
						st_nxt.perr_lock = 1'b0; // R12
						st_nxt.ptype     = '0; // R12
					end
					if (wr_val[POS_SEO]) begin
						st_nxt.second_error_flag = 1'b0; // R13
					end
				end
				OFF_INV_PROCESS: begin
					for (int i = 0; i < TB_ENTRIES; i++) begin
						if (!st_r.tb[i].global_match_bit) begin
							st_nxt.tb[i].valid = 1'b0; // R16
						end
					end
				end
				OFF_INV_ALL: begin
					for (int i = 0; i < TB_ENTRIES; i++) begin
						st_nxt.tb[i].valid = 1'b0; // R17
					end
					st_nxt.ptr = '0; // R17
				end
				OFF_INV_SINGLE_L: begin
					st_nxt.inv_low = merge(st_r.inv_low, st_r.w_data, st_r.w_strb);
				end
				OFF_INV_SINGLE_H: begin
					// The high word completes the address and fires the operation.
					inv_addr   = {merge(32'h0, st_r.w_data, st_r.w_strb), st_r.inv_low};
					inv_single = !(fetch_tb_miss || pc_mispredict || user_mode); // R20
				end
				OFF_CONTROL: begin
					wr_val = merge({30'h0, st_r.entry32_mode, 1'b0}, st_r.w_data, st_r.w_strb);
					st_nxt.entry32_mode = wr_val[POS_ENTRY32];
				end
				OFF_SPACE_NUM: begin
					wr_val = merge({25'h0, st_r.space_number}, st_r.w_data, st_r.w_strb);
					st_nxt.space_number = wr_val[ASN_W-1:0];
				end
				default: begin
					st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (inv_single) begin
			for (int i = 0; i < TB_ENTRIES; i++) begin
				if (st_r.tb[i].page == inv_addr[42:13] &&
					(st_r.tb[i].space_number == st_r.space_number || // R18
					st_r.tb[i].global_match_bit)) begin // R19
					st_nxt.tb[i].valid = 1'b0;
				end
			end
		end

		if (ar_take) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			case (araddr)
				OFF_ENTRY_PORT: begin
					st_nxt.hold = st_r.tb[st_r.ptr].pte; // R01
					st_nxt.ptr  = st_r.ptr + PTR_W'(1);
				end
				OFF_HOLD_LO: begin
					st_nxt.rdata = st_r.hold[31:0]; // R01
				end
				OFF_HOLD_HI: begin
					st_nxt.rdata = st_r.hold[63:32]; // R01
				end
				OFF_FAULT_STAT: begin
					st_nxt.rdata = {15'h0, st_r.fstat};
				end
				OFF_FADDR_LO: begin
					st_nxt.rdata = st_r.faddr[31:0];
				end
				OFF_FADDR_HI: begin
					// Read low word first: this read releases the capture.
					st_nxt.rdata = st_r.faddr[63:32];
					unlock_read  = 1'b1; // R02
				end
				OFF_FORM_LO: begin
					st_nxt.rdata = st_r.form[31:0];
				end
				OFF_FORM_HI: begin
					st_nxt.rdata = st_r.form[63:32];
				end
				OFF_BASE_LO, OFF_BASE_HI, OFF_INV_PROCESS, OFF_INV_ALL, OFF_INV_SINGLE_L,
				OFF_INV_SINGLE_H: begin
					st_nxt.rdata = 32'h0000_0000;
				end
				OFF_PARITY_STAT: begin
					st_nxt.rdata = {26'h0, st_r.ptype, st_r.perr_lock, st_r.second_error_flag}; // R15
				end
				OFF_CONTROL: begin
					st_nxt.rdata = {30'h0, st_r.entry32_mode, 1'b0};
				end
				OFF_SPACE_NUM: begin
					st_nxt.rdata = {25'h0, st_r.space_number};
				end
				OFF_TB_STATUS: begin
					st_nxt.rdata = {18'h0, st_r.ptr, valid_cnt};
				end
				default: begin
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Unlock first, then a coincident fault is captured normally.
		fault_lock_eff = st_r.fault_lock && !unlock_read; // R21
		if (unlock_read) begin
			st_nxt.fault_lock = 1'b0; // R02
		end

		perr_any  = (|perr_pipe0) || (|perr_pipe1);
		fault_any = fault_in.valid || perr_any;
		ev_stat   = fault_in.valid ? fault_in.stat : '0; // R05 R06
		ev_addr   = fault_in.valid ? fault_in.vaddr : perr_vaddr;
		if (fault_any && !fault_lock_eff) begin
			st_nxt.fault_lock = 1'b1; // R02
			st_nxt.fstat      = ev_stat; // R03
			st_nxt.faddr      = ev_addr; // R07
			st_nxt.form       = format_addr(st_r.base, ev_addr, st_r.entry32_mode);
		end

		// A set from hardware wins over a software clear in the same cycle.
		lock_eff = st_r.perr_lock && st_nxt.perr_lock;
		if (perr_any) begin
			if (!lock_eff) begin
				st_nxt.ptype     = perr_pipe0 | perr_pipe1; // R11 R14
				st_nxt.perr_lock = 1'b1; // R11
			end else begin
				st_nxt.second_error_flag = 1'b1; // R13
			end
		end

		if (fill_valid) begin
			st_nxt.tb[st_r.ptr].valid            = 1'b1;
			st_nxt.tb[st_r.ptr].global_match_bit = fill_in.global_match_bit;
			st_nxt.tb[st_r.ptr].space_number     = fill_in.space_number;
			st_nxt.tb[st_r.ptr].page             = fill_in.page;
			st_nxt.tb[st_r.ptr].pte              = fill_in.pte;
			if (!(ar_take && araddr == OFF_ENTRY_PORT)) begin
				st_nxt.ptr = st_r.ptr + PTR_W'(1);
			end
		end

		// Ordinary reset leaves the captured fault and parity state alone.
		if (reset) begin // R04
			st_nxt.aw_got       = 1'b0;
			st_nxt.w_got        = 1'b0;
			st_nxt.bvalid       = 1'b0;
			st_nxt.bresp        = RESP_OKAY;
			st_nxt.rvalid       = 1'b0;
			st_nxt.rdata        = 32'h0000_0000;
			st_nxt.rresp        = RESP_OKAY;
			st_nxt.entry32_mode = 1'b0;
			st_nxt.ptr          = '0;
			for (int i = 0; i < TB_ENTRIES; i++) begin
				st_nxt.tb[i].valid = 1'b0;
			end
		end
		if (power_on) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign awready = !st_r.aw_got && !st_r.bvalid;
	assign wready  = !st_r.w_got && !st_r.bvalid;
	assign bvalid  = st_r.bvalid;
	assign bresp   = st_r.bresp;
	assign arready = !st_r.rvalid;
	assign rvalid  = st_r.rvalid;
	assign rdata   = st_r.rdata;
	assign rresp   = st_r.rresp;

endmodule : dstream_mmu

//--- hw/dstream_mmu_pkg.sv
// Constants, field layouts and carrier types for the data-stream fault and invalidate block.
// Contract
// (R01) Reading the entry port copies the selected entry to the holding register, returns zero.
// (R02) Captured status, address and formatted address hold until software reads the address.
// (R03) Hardware updates fault status only while unlocked, on fault, miss or parity error.
// (R04) Reset neither unlocks nor clears the fault and parity status registers.
// (R05) Status bits: write, access violation, fault-on-read, fault-on-write, miss, bad address.
// (R06) Status bits 10:6 hold destination register field, bits 16:11 the opcode.
// (R07) Fault, miss or parity error latches the effective address while unlocked.
// (R08) Normal mode: table base in 63:33, address bits 42:13 in 32:3.
// (R09) 32-bit entry mode: table base in 63:30, address bits 31:13 in 21:3.
// (R10) Page table base is always writable and never locked by captures.
// (R11) Parity error while unlocked loads type bits 5:2 and sets the lock flag.
// (R12) Writing one to lock bit 1 clears it and clears type bits 5:2.
// (R13) Parity error while locked sets second-error bit 0 until software writes one.
// (R14) Errors on both pipes in one cycle set no second-error flag, only type bits.
// (R15) Type bits: 2 data bank0, 3 data bank1, 4 tag bank0, 5 tag bank1.
// (R16) Any write to invalidate-process drops every entry whose global bit is zero.
// (R17) Any write to invalidate-all drops all 64 entries and resets the replacement pointer.
// (R18) Invalidate-single drops entries matching page bits 42:13 and the space number.
// (R19) Invalidate-single also drops matching-page entries with the global bit set.
// (R20) Invalidate-single is cancelled only by fetch miss, mispredict or user-mode issue.
// (R21) A fault coinciding with the unlocking read is captured after the unlock.
package dstream_mmu_pkg;

	localparam int TB_ENTRIES = 64;
	localparam int PTR_W      = 6;
	localparam int ASN_W      = 7;
	localparam int PAGE_W     = 30;

	// Byte offsets on the register bus; 64-bit registers take a low and a high word.
	localparam logic [7:0] OFF_ENTRY_PORT   = 8'h00;
	localparam logic [7:0] OFF_HOLD_LO      = 8'h08;
	localparam logic [7:0] OFF_HOLD_HI      = 8'h0c;
	localparam logic [7:0] OFF_FAULT_STAT   = 8'h10;
	localparam logic [7:0] OFF_FADDR_LO     = 8'h18;
	localparam logic [7:0] OFF_FADDR_HI     = 8'h1c;
	localparam logic [7:0] OFF_FORM_LO      = 8'h20;
	localparam logic [7:0] OFF_FORM_HI      = 8'h24;
	localparam logic [7:0] OFF_BASE_LO      = 8'h28;
	localparam logic [7:0] OFF_BASE_HI      = 8'h2c;
	localparam logic [7:0] OFF_PARITY_STAT  = 8'h30;
	localparam logic [7:0] OFF_INV_PROCESS  = 8'h38;
	localparam logic [7:0] OFF_INV_ALL      = 8'h40;
	localparam logic [7:0] OFF_INV_SINGLE_L = 8'h48;
	localparam logic [7:0] OFF_INV_SINGLE_H = 8'h4c;
	localparam logic [7:0] OFF_CONTROL      = 8'h50;
	localparam logic [7:0] OFF_SPACE_NUM    = 8'h54;
	localparam logic [7:0] OFF_TB_STATUS    = 8'h58;

	localparam int POS_SEO       = 0;
	localparam int POS_LOCK      = 1;
	localparam int POS_TYPE_LO   = 2;
	localparam int POS_ENTRY32   = 1;
	localparam int POS_VALIDS_LO = 8;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Parity error type, low bit first: data bank0, data bank1, tag bank0, tag bank1.
	typedef struct packed {
		logic tag_err_bank1;
		logic tag_err_bank0;
		logic data_err_bank1;
		logic data_err_bank0;
	} perr_type_t;

	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] dest_reg_field;
		logic       bad_address_flag;
		logic       tb_miss_flag;
		logic       fault_on_write_flag;
		logic       fault_on_read_flag;
		logic       access_violation_flag;
		logic       write_ref;
	} fault_stat_t;

	typedef struct packed {
		logic        valid;
		fault_stat_t stat;
		logic [63:0] vaddr;
	} fault_event_t;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [ASN_W-1:0]  space_number;
		logic              global_match_bit;
		logic [63:0]       pte;
	} fill_t;

	typedef struct packed {
		logic              valid;
		logic              global_match_bit;
		logic [ASN_W-1:0]  space_number;
		logic [PAGE_W-1:0] page;
		logic [63:0]       pte;
	} tb_entry_t;

endpackage : dstream_mmu_pkg

//--- dv/dstream_mmu_checker.sv
// Bus handshake and read-value checks for the data-stream fault block.
`timescale 1ns/1ps
module dstream_mmu_checker
	import dstream_mmu_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset,
	input wire logic         power_on,
	input wire logic         awready,
	input wire logic         wready,
	input wire logic         bvalid,
	input wire logic         bready,
	input wire logic [1:0]   bresp,
	input wire logic         arvalid,
	input wire logic         arready,
	input wire logic [7:0]   araddr,
	input wire logic         rvalid,
	input wire logic [31:0]  rdata,
	input wire logic [1:0]   rresp,
	input wire fault_event_t fault_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || power_on);
	chk_b_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted during response");
	chk_r_refuse: assert property (rvalid |-> !arready)
		else $error("read accepted during read data");
	chk_r_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	chk_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not freed");
	chk_port_zero: assert property (arvalid && arready && araddr == OFF_ENTRY_PORT |=>
		rdata == 32'h0)
		else $error("entry port read not zero");
	chk_wo_zero: assert property (arvalid && arready && araddr == OFF_INV_ALL |=>
		rdata == 32'h0 && rresp == RESP_OKAY)
		else $error("write-only read not zero");
	chk_bresp_code: assert property ($rose(bvalid) |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
		else $error("bad write response code");
	chk_b_single: assert property ($rose(bvalid) |-> ##1 !bvalid || !bready)
		else $error("write response held too long");
	cover property (bvalid && bresp == RESP_SLVERR);
	cover property (rvalid && araddr == OFF_FADDR_HI);
	cover property (fault_in.valid);
endmodule : dstream_mmu_checker

bind dstream_mmu dstream_mmu_checker i_dstream_mmu_checker (.clk(clk), .reset(reset),
	.power_on(power_on), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
	.rdata(rdata), .rresp(rresp), .fault_in(fault_in));

//--- dv/dstream_mmu_tb.sv
// Self-checking testbench for the data-stream fault and invalidate block.
`timescale 1ns/1ps
module dstream_mmu_tb import dstream_mmu_pkg::*;;
	logic         clk = 1'b0;
	logic         reset = 1'b1, power_on = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic         fill_valid = 1'b0, fetch_tb_miss = 1'b0, pc_mispredict = 1'b0, user_mode = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid;
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]  wdata = 32'h0, rdata;
	logic [1:0]   bresp, rresp;
	logic [63:0]  perr_vaddr = 64'h0;
	fault_event_t fault_in = '0;
	perr_type_t   perr_pipe0 = '0, perr_pipe1 = '0;
	fill_t        fill_in = '0;
	int           fails = 0, samples_checked = 0;

	always #25 clk = ~clk;

	dstream_mmu i_dstream_mmu (.clk(clk), .reset(reset), .power_on(power_on), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(1'b1), .rdata(rdata), .rresp(rresp), .fault_in(fault_in),
		.perr_pipe0(perr_pipe0), .perr_pipe1(perr_pipe1), .perr_vaddr(perr_vaddr),
		.fill_valid(fill_valid), .fill_in(fill_in), .fetch_tb_miss(fetch_tb_miss),
		.pc_mispredict(pc_mispredict), .user_mode(user_mode));

	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	function logic [63:0] fmt(input logic [63:0] b, input logic [63:0] v, input logic m);
		return m ? {b[63:30], 8'h00, v[31:13], 3'h0} : {b[63:33], v[42:13], 3'h0};
	endfunction : fmt

	// Ready is sampled at the falling edge, where it has settled, and acted on at the next rise.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		cmp("bresp", 64'(er), 64'(r));
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		d = rdata;
		cmp("rresp", 64'(RESP_OKAY), 64'(rresp));
		@(posedge clk);
	endtask : rd

	task rd64(input logic [7:0] a, output logic [63:0] d);
		rd(a, d[31:0]);
		rd(a + 8'h04, d[63:32]);
	endtask : rd64

	task ev(input fault_stat_t s, input logic [63:0] v);
		fault_in <= {1'b1, s, v};
		@(posedge clk);
		fault_in <= '0;
		@(posedge clk);
	endtask : ev

	task pe(input perr_type_t p0, input perr_type_t p1);
		perr_pipe0 <= p0;
		perr_pipe1 <= p1;
		@(posedge clk);
		perr_pipe0 <= '0;
		perr_pipe1 <= '0;
		@(posedge clk);
	endtask : pe

	task pchk(input logic [7:0] e);
		logic [31:0] d;
		rd(OFF_PARITY_STAT, d);
		cmp("parity", 64'(e), 64'(d));
	endtask : pchk

	task cnt(input logic [7:0] e);
		logic [31:0] d;
		rd(OFF_TB_STATUS, d);
		cmp("valid count", 64'(e), 64'(d[7:0]));
	endtask : cnt

	task t_fault;
		logic [63:0] d, va;
		fault_stat_t s;
		wr(OFF_BASE_LO, 32'h0, RESP_OKAY);
		wr(OFF_BASE_HI, 32'h12345676, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			s = {6'(i + 1), 5'h13, 6'(1 << i)};
			va = 64'h0000_0123_4567_8000 + 64'(i << 13);
			ev(s, va);
			ev(~s, ~va);
			if (i == 0) begin
				reset <= 1'b1;
				repeat (2) @(posedge clk);
				reset <= 1'b0;
				repeat (2) @(posedge clk);
			end
			rd(OFF_FAULT_STAT, d[31:0]);
			cmp("status", 64'(s), 64'(d[31:0]));
			rd64(OFF_FORM_LO, d);
			cmp("format", fmt(64'h12345676_00000000, va, 1'b0), d);
			rd64(OFF_FADDR_LO, d);
			cmp("address", va, d);
		end
		wr(OFF_CONTROL, 32'h2, RESP_OKAY);
		wr(OFF_BASE_HI, 32'habcdef00, RESP_OKAY);
		wr(OFF_BASE_LO, 32'h40000000, RESP_OKAY);
		ev(s, va);
		// The base stays writable while the capture is locked.
		wr(OFF_BASE_HI, 32'h11111111, RESP_OKAY);
		rd64(OFF_FORM_LO, d);
		cmp("format", fmt(64'habcdef00_40000000, va, 1'b1), d);
		rd64(OFF_FADDR_LO, d);
		ev(s, va);
		rd64(OFF_FORM_LO, d);
		cmp("format", fmt(64'h11111111_40000000, va, 1'b1), d);
		rd64(OFF_FADDR_LO, d);
		wr(OFF_CONTROL, 32'h0, RESP_OKAY);
	endtask : t_fault

	task t_parity;
		logic [63:0] d;
		perr_vaddr <= 64'h0000_0456_789a_c000;
		pe(4'b0010, 4'b0000);
		pchk(8'h0a);
		pe(4'b0001, 4'b0000);
		pchk(8'h0b);
		rd64(OFF_FADDR_LO, d);
		cmp("address", 64'h0000_0456_789a_c000, d);
		wr(OFF_PARITY_STAT, 32'h2, RESP_OKAY);
		pchk(8'h01);
		wr(OFF_PARITY_STAT, 32'h1, RESP_OKAY);
		pchk(8'h00);
		pe(4'b0101, 4'b1000);
		pchk(8'h36);
		wr(OFF_PARITY_STAT, 32'h2, RESP_OKAY);
		rd64(OFF_FADDR_LO, d);
	endtask : t_parity

	task t_tb;
		logic [63:0] d;
		fill_valid <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			fill_in <= {30'(i), 7'h05, i[0], 32'hc0de0000, 32'(i)};
			@(posedge clk);
		end
		fill_valid <= 1'b0;
		rd(OFF_ENTRY_PORT, d[31:0]);
		cmp("port", 64'h0, 64'(d[31:0]));
		rd64(OFF_HOLD_LO, d);
		cmp("holding", 64'hc0de0000_00000000, d);
		rd(OFF_TB_STATUS, d[31:0]);
		cmp("pointer", 64'h1, 64'(d[13:8]));
		cnt(8'h40);
		wr(OFF_SPACE_NUM, 32'h5, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			// Cancelled attempts come first, so one wrongly applied shows in the count.
			{fetch_tb_miss, pc_mispredict, user_mode} <= 3'((8 >> i) >> 1);
			wr(OFF_INV_SINGLE_L, 32'h0000_4000, RESP_OKAY);
			wr(OFF_INV_SINGLE_H, 32'h0, RESP_OKAY);
			cnt((i == 3) ? 8'h3f : 8'h40);
		end
		{fetch_tb_miss, pc_mispredict, user_mode} <= 3'h0;
		wr(OFF_SPACE_NUM, 32'h6, RESP_OKAY);
		wr(OFF_INV_SINGLE_L, 32'h0000_8000, RESP_OKAY);
		wr(OFF_INV_SINGLE_H, 32'h0, RESP_OKAY);
		cnt(8'h3f);
		wr(OFF_INV_SINGLE_L, 32'h0000_6000, RESP_OKAY);
		wr(OFF_INV_SINGLE_H, 32'h0, RESP_OKAY);
		cnt(8'h3e);
		wr(OFF_INV_PROCESS, 32'h0, RESP_OKAY);
		cnt(8'h1f);
		wr(OFF_INV_ALL, 32'h0, RESP_OKAY);
		rd(OFF_TB_STATUS, d[31:0]);
		cmp("pointer", 64'h0, 64'(d[13:8]));
		cmp("valid count", 64'h0, 64'(d[7:0]));
		wr(8'h5c, 32'h0, RESP_SLVERR);
		rd(OFF_INV_ALL, d[31:0]);
		cmp("write-only", 64'h0, 64'(d[31:0]));
	endtask : t_tb

	initial begin
		#1000000;
		fails++;
		stop_test;
	end

	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		power_on <= 1'b0;
		@(posedge clk);
		t_fault;
		t_parity;
		t_tb;
		stop_test;
	end
endmodule : dstream_mmu_tb
